// ### rtl/sram_cmd_decode.sv
`timescale 1ns/1ps
module sram_cmd_decode #(
	parameter int LANES = 4
) (
	// chip selects
	input wire logic chip_sel_primary_n,
	input wire logic chip_sel_second_hi,
	input wire logic chip_sel_third_n,
	// strobes
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	// write enables
	input wire logic global_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [LANES-1:0] byte_lane_write_n,
	// decoded command
	sram_cmd_if.dec cmd
);
	// selection needs all three enables at their active level
	always_comb
	begin
		cmd.selected = !chip_sel_primary_n && chip_sel_second_hi && !chip_sel_third_n;
		cmd.start = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
		// full width: global write, or gate with every lane low
		cmd.full_write = !global_write_n ||
			(!byte_write_gate_n && (byte_lane_write_n == '0));
		// partial write only through the gate
		cmd.lane_write = !byte_write_gate_n && (byte_lane_write_n != '1);
	end
endmodule

// ### rtl/sram_cmd_if.sv
`timescale 1ns/1ps
interface sram_cmd_if #(parameter int LANES = 4);
	logic selected;
	logic start;
	logic full_write;
	logic lane_write;
	modport dec (output selected, output start, output full_write, output lane_write);
	modport core (input selected, input start, input full_write, input lane_write);
endinterface

// ### rtl/sram_slice_map.svh
`ifndef SRAM_SLICE_MAP_SVH
`define SRAM_SLICE_MAP_SVH
// power-up wait before the first access, in microseconds
`define PWR_WAIT_US 1000
// clock rate in MHz
`define CLK_MHZ 10
// power-up wait in cycles (least time, rounds up)
`define PWR_WAIT_CYC ((`PWR_WAIT_US * `CLK_MHZ))
// bits in one byte lane of the data bus
`define LANE_W 9
`endif

// ### rtl/sram_slice_pkg.sv
package sram_slice_pkg;
	// access decoded from the strobes and enables
	typedef enum logic [1:0] {ACC_NONE, ACC_READ, ACC_WRITE} acc_t;
endpackage

// ### rtl/sync_sram_select_write_sleep.sv
`timescale 1ns/1ps
`include "sram_slice_map.svh"
// How it works
// - selected only when primary low, second high, third low
// - full write on global low, or gate and lanes low
// - data stays high impedance after writes until new read
// - data lines high impedance when leaving sleep
// - sleep holds contents unchanged, low power
module sync_sram_select_write_sleep #(
	parameter int LANES = 4,
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int PWR_WAIT = `PWR_WAIT_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// chip selects
	input wire logic chip_sel_primary_n,
	input wire logic chip_sel_second_hi,
	input wire logic chip_sel_third_n,
	// strobes and write enables
	input wire logic proc_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic global_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [LANES-1:0] byte_lane_write_n,
	// address and sleep
	input wire logic [AW-1:0] addr,
	input wire logic sleep_request,
	// data pins, three signals
	input wire logic [LANES*`LANE_W-1:0] dq_in,
	output logic [LANES*`LANE_W-1:0] dq_out,
	output logic dq_oe,
	// status
	output logic sleeping,
	output logic ready
);
	localparam int W = LANES*`LANE_W;
	sram_cmd_if #(.LANES(LANES)) cmd ();
	sram_cmd_decode #(.LANES(LANES)) u_dec (
		.chip_sel_primary_n(chip_sel_primary_n),
		.chip_sel_second_hi(chip_sel_second_hi),
		.chip_sel_third_n(chip_sel_third_n),
		.proc_addr_strobe_n(proc_addr_strobe_n),
		.ctrl_addr_strobe_n(ctrl_addr_strobe_n),
		.global_write_n(global_write_n),
		.byte_write_gate_n(byte_write_gate_n),
		.byte_lane_write_n(byte_lane_write_n),
		.cmd(cmd)
	);
	////////////////////////////////////////////////////////////////
	// storage, no reset on purpose: contents survive everything
	logic [W-1:0] mem [DEPTH];
	// read data and its drive enable, both held in flops for the pins
	logic [W-1:0] dq_out_r, dq_out_nxt;
	logic dq_oe_r, dq_oe_nxt; // high while the data pins are driven
	// sleep copy; its extra cycle also refuses the waking edge
	logic sleep_r, sleep_nxt;
	// power-up counter, advisory only: nothing here refuses early access
	logic [31:0] pwr_cnt_r, pwr_cnt_nxt;
	logic ready_r, ready_nxt; // stays high once the wait has elapsed
	// what the current edge does
	sram_slice_pkg::acc_t acc;
	// access kind; sleep blocks everything so contents stay put
	always_comb
	begin
		acc = sram_slice_pkg::ACC_NONE;
		// the waking edge is refused too, so the bus leaves sleep floating
		if (!sleep_request && !sleep_r && cmd.selected && cmd.start)
		begin
			if (cmd.full_write || cmd.lane_write)
				acc = sram_slice_pkg::ACC_WRITE;
			else
				acc = sram_slice_pkg::ACC_READ;
		end
	end
	// write port, per lane
	always_ff @(posedge sys_clk)
	begin
		if (acc == sram_slice_pkg::ACC_WRITE)
		begin
			for (int l = 0; l < LANES; l++)
				if (cmd.full_write || !byte_lane_write_n[l])
					mem[addr][l*`LANE_W +: `LANE_W] <= dq_in[l*`LANE_W +: `LANE_W];
		end
	end
	////////////////////////////////////////////////////////////////
	// output driver and sleep state next values
	always_comb
	begin
		dq_out_nxt = dq_out_r;
		dq_oe_nxt = dq_oe_r;
		sleep_nxt = sleep_request;
		pwr_cnt_nxt = pwr_cnt_r;
		ready_nxt = ready_r;
		if (pwr_cnt_r < PWR_WAIT)
			pwr_cnt_nxt = pwr_cnt_r + 32'h1;
		else
			ready_nxt = 1'b1;
		if (sleep_request || sleep_r)
			dq_oe_nxt = 1'b0;
		else if (acc == sram_slice_pkg::ACC_READ)
		begin
			dq_oe_nxt = 1'b1;
			dq_out_nxt = mem[addr];
		end
		else if (acc == sram_slice_pkg::ACC_WRITE || !cmd.selected)
			dq_oe_nxt = 1'b0;
	end
	// registers only
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dq_out_r <= '0;
			dq_oe_r <= 1'b0;
			sleep_r <= 1'b0;
			pwr_cnt_r <= 32'h0;
			ready_r <= 1'b0;
		end
		else
		begin
			dq_out_r <= dq_out_nxt;
			dq_oe_r <= dq_oe_nxt;
			sleep_r <= sleep_nxt;
			pwr_cnt_r <= pwr_cnt_nxt;
			ready_r <= ready_nxt;
		end
	end
	assign dq_out = dq_out_r;
	assign dq_oe = dq_oe_r;
	assign sleeping = sleep_r;
	assign ready = ready_r;
	////////////////////////////////////////////////////////////////
	// checks
	property p_wr_hiz;
		@(posedge sys_clk) disable iff (!rst_n)
		(acc == sram_slice_pkg::ACC_WRITE) |=> !dq_oe;
	endproperty
	a_wr_hiz: assert property (p_wr_hiz) else $error("bus driven after write");
	property p_hold_hiz;
		@(posedge sys_clk) disable iff (!rst_n)
		(!dq_oe && acc != sram_slice_pkg::ACC_READ) |=> !dq_oe;
	endproperty
	a_hold_hiz: assert property (p_hold_hiz) else $error("bus driven without read");
	property p_sleep_hiz;
		@(posedge sys_clk) disable iff (!rst_n)
		sleep_request |=> !dq_oe && sleeping;
	endproperty
	a_sleep_hiz: assert property (p_sleep_hiz) else $error("bus driven in sleep");
	property p_exit_hiz;
		@(posedge sys_clk) disable iff (!rst_n)
		$fell(sleeping) |-> !dq_oe;
	endproperty
	a_exit_hiz: assert property (p_exit_hiz) else $error("bus driven leaving sleep");
	property p_sel;
		@(posedge sys_clk) disable iff (!rst_n)
		cmd.selected == (!chip_sel_primary_n && chip_sel_second_hi && !chip_sel_third_n);
	endproperty
	a_sel: assert property (p_sel) else $error("select decode wrong");
	property p_full;
		@(posedge sys_clk) disable iff (!rst_n)
		(global_write_n && byte_write_gate_n) |-> !cmd.full_write;
	endproperty
	a_full: assert property (p_full) else $error("full write without enable");
	property p_sleep_noacc;
		@(posedge sys_clk) disable iff (!rst_n)
		sleep_request |-> acc == sram_slice_pkg::ACC_NONE;
	endproperty
	a_sleep_noacc: assert property (p_sleep_noacc) else $error("access during sleep");
	property p_read_drive;
		@(posedge sys_clk) disable iff (!rst_n)
		(acc == sram_slice_pkg::ACC_READ) |=> dq_oe;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven");
	// no access may be taken on the waking edge either
	property p_wake_noacc;
		@(posedge sys_clk) disable iff (!rst_n)
		sleeping |-> acc == sram_slice_pkg::ACC_NONE;
	endproperty
	a_wake_noacc: assert property (p_wake_noacc) else $error("access on wake");
	// the bus stays floating for the whole sleep
	property p_sleep_float;
		@(posedge sys_clk) disable iff (!rst_n)
		sleeping |-> !dq_oe;
	endproperty
	a_sleep_float: assert property (p_sleep_float) else $error("driven asleep");
	// a deselected edge floats the bus, whatever the strobes do
	property p_desel_hiz;
		@(posedge sys_clk) disable iff (!rst_n)
		!cmd.selected |=> !dq_oe;
	endproperty
	a_desel_hiz: assert property (p_desel_hiz) else $error("driven deselected");
	// nothing is taken unless the part is selected
	property p_acc_sel;
		@(posedge sys_clk) disable iff (!rst_n)
		(acc != sram_slice_pkg::ACC_NONE) |-> cmd.selected;
	endproperty
	a_acc_sel: assert property (p_acc_sel) else $error("access deselected");
	// global write alone makes a full-width write
	property p_gw_full;
		@(posedge sys_clk) disable iff (!rst_n)
		!global_write_n |-> cmd.full_write;
	endproperty
	a_gw_full: assert property (p_gw_full) else $error("global write not full");
	// gate with every lane low is full width as well
	property p_gate_full;
		@(posedge sys_clk) disable iff (!rst_n)
		(!byte_write_gate_n && byte_lane_write_n == '0) |-> cmd.full_write;
	endproperty
	a_gate_full: assert property (p_gate_full) else $error("lane write not full");
	// lanes alone never write while the gate is off
	property p_gate_off;
		@(posedge sys_clk) disable iff (!rst_n)
		byte_write_gate_n |-> !cmd.lane_write;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("lane write without gate");
	// the power-up flag never falls back once raised
	property p_ready_keep;
		@(posedge sys_clk) disable iff (!rst_n)
		ready |=> ready;
	endproperty
	a_ready_keep: assert property (p_ready_keep) else $error("ready fell");
endmodule

// ### test/host_ctl.sv
`timescale 1ns/1ps
module host_ctl (
	// clock
	input wire logic sys_clk,
	// selects, strobes and write enables
	output logic chip_sel_primary_n,
	output logic chip_sel_second_hi,
	output logic chip_sel_third_n,
	output logic proc_addr_strobe_n,
	output logic ctrl_addr_strobe_n,
	output logic global_write_n,
	output logic byte_write_gate_n,
	output logic [3:0] byte_lane_write_n,
	// address, sleep and data
	output logic [3:0] addr,
	output logic sleep_request,
	output logic [35:0] dq_in
);
	// idle is deselected, so sleep may be raised at any time
	task automatic idle;
	begin
		{chip_sel_primary_n, chip_sel_second_hi, chip_sel_third_n} = 3'h5;
		{proc_addr_strobe_n, ctrl_addr_strobe_n, global_write_n, byte_write_gate_n} = 4'hF;
		byte_lane_write_n = 4'hF;
		// released data never keeps its last value
		dq_in = ~dq_in;
	end
	endtask
	initial
	begin
		addr = 4'h0;
		sleep_request = 1'b0;
		dq_in = 36'h0;
		idle();
	end
	// one request left standing for the next edge; wm 0 read, 1 global write,
	// 2 gate with all lanes; go low keeps both strobes off
	task automatic drive(input logic [2:0] cs, input logic [1:0] wm, input logic [3:0] a,
		input logic [35:0] d, input logic go);
	begin
		@(posedge sys_clk);
		#1;
		{chip_sel_primary_n, chip_sel_second_hi, chip_sel_third_n} = cs;
		// address bit 0 picks which strobe starts the access
		proc_addr_strobe_n = a[0] | ~go;
		ctrl_addr_strobe_n = ~a[0] | ~go;
		global_write_n = (wm != 2'h1);
		byte_write_gate_n = (wm != 2'h2);
		byte_lane_write_n = (wm == 2'h2) ? 4'h0 : 4'hF;
		addr = a;
		if (wm != 2'h0)
			dq_in = d;
	end
	endtask
	// let the standing request be taken, then release the bus
	task automatic rest;
	begin
		@(posedge sys_clk);
		#1;
		idle();
	end
	endtask
	// one whole access
	task automatic cyc(input logic [2:0] cs, input logic [1:0] wm, input logic [3:0] a,
		input logic [35:0] d);
	begin
		drive(cs, wm, a, d, 1'b1);
		rest();
	end
	endtask
	// sleep level change; raised only while deselected
	task automatic nap(input logic v);
	begin
		@(posedge sys_clk);
		#1;
		sleep_request = v;
	end
	endtask
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic chip_sel_primary_n, chip_sel_second_hi, chip_sel_third_n, proc_addr_strobe_n;
	logic ctrl_addr_strobe_n, global_write_n, byte_write_gate_n, sleep_request;
	logic dq_oe, sleeping, ready;
	logic [3:0] byte_lane_write_n, addr;
	logic [35:0] dq_in, dq_out;
	int error_cnt = 0;
	int n_tests = 0;
	// 10 MHz clock
	always #50 sys_clk = ~sys_clk;
	// short power-up count keeps the run brief
	sync_sram_select_write_sleep #(.PWR_WAIT(8)) dut_u (.*);
	host_ctl h (.*);
	task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
	begin
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	end
	endtask
	task automatic test_done;
	begin
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	// every select pattern; only low, high, low may answer
	task automatic t_sel;
	begin
		for (int i = 0; i < 8; i++)
		begin
			h.cyc(i[2:0], 2'h0, 4'h1, 36'h0);
			chk("dq_oe select", 36'(i == 2), dq_oe);
		end
		$display("select test done");
	end
	endtask
	// both full-write forms, bus floats after each
	task automatic t_wr;
	begin
		h.cyc(3'h2, 2'h1, 4'h3, 36'hA5A5A5A5A);
		chk("dq_oe after write", 36'h0, dq_oe);
		h.cyc(3'h2, 2'h2, 4'h4, 36'h123456789);
		chk("dq_oe after write", 36'h0, dq_oe);
		h.cyc(3'h2, 2'h0, 4'h3, 36'h0);
		chk("global write", 36'hA5A5A5A5A, dq_out);
		h.cyc(3'h2, 2'h0, 4'h4, 36'h0);
		chk("lane write", 36'h123456789, dq_out);
		// read then write back to back: the write must float the bus
		h.drive(3'h2, 2'h0, 4'h3, 36'h0, 1'b1);
		h.drive(3'h2, 2'h1, 4'h5, 36'h0F0F0F0F0, 1'b1);
		chk("dq_oe on read", 36'h1, dq_oe);
		chk("read back", 36'hA5A5A5A5A, dq_out);
		h.drive(3'h2, 2'h0, 4'h5, 36'h0, 1'b0);
		chk("dq_oe after write", 36'h0, dq_oe);
		h.rest();
		chk("dq_oe selected idle", 36'h0, dq_oe);
		$display("write test done");
	end
	endtask
	// write during sleep is dropped, bus floats on exit
	task automatic t_sleep;
	begin
		h.nap(1'b1);
		h.cyc(3'h2, 2'h1, 4'h3, 36'h0);
		chk("sleeping", 36'h1, sleeping);
		// read asked for during sleep and held across the waking edge
		h.drive(3'h2, 2'h0, 4'h3, 36'h0, 1'b1);
		h.nap(1'b0);
		h.drive(3'h2, 2'h0, 4'h3, 36'h0, 1'b1);
		chk("dq_oe on wake", 36'h0, dq_oe);
		chk("sleeping on wake", 36'h0, sleeping);
		h.rest();
		chk("dq_oe after wake", 36'h1, dq_oe);
		chk("kept data", 36'hA5A5A5A5A, dq_out);
		$display("sleep test done");
	end
	endtask
	initial
	begin
		repeat (20) @(posedge sys_clk);
		#1;
		chk("dq_oe in reset", 36'h0, dq_oe);
		rst_n = 1'b1;
		// first access only after the power-up wait
		for (int i = 0; i < 20 && ready !== 1'b1; i++)
			@(posedge sys_clk);
		#1;
		chk("ready", 36'h1, ready);
		t_sel();
		t_wr();
		t_sleep();
		test_done();
	end
	// watchdog well past the expected run
	initial
	begin
		#(2000 * 100);
		error_cnt++;
		test_done();
	end
endmodule
